// ==== io_port_pin_sharing_slice.sv ====
// I/O port slice: seven-bit port F (pins 7:1) and five-bit port G.
// Pins arrive from the pad ring asynchronously; peripherals share core_clk.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// R01: Pin 6 drives latch when output, analog ignored
// R02: Pin 6 input reads pin, zero if analog
// R03: Pin 6 resets analog, output still drives
// R04: Pin 7 drives latch when output, analog ignored
// R05: Pin 7 input reads pin, zero if analog
// R06: Pin 7 resets to analog channel five
// R07: Pin 7 input feeds serial slave select
// R08: Port F bit zero reads zero
// R09: Port G has five pins, dir and latch
// R10: Open-drain control for capture and transmit
// R11: Peripheral may force pin in or out
// R12: Overrides never stored in direction register
// R13: Channel 3 output overrides latch on G0
// R14: Channel 3 output tristates on PWM shutdown
// R15: Serial transmit drives G1 even as input
// R16: G1 feeds serial clock when external clock
// R17: G1 resets analog, output still drives
// R18: Don't-care functions ignore the direction bit
// R19: Reset makes F pins analog, reads zero
// R20: Data write loads latch; latch reads back
// R21: Selected comparator output overrides the latch
module io_port_pin_sharing_slice
    import gpio_slice_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    // Port F pads
    input  wire logic [7:1]        port_f_pin_in,
    output logic      [7:1]        port_f_pin_out,
    output logic      [7:1]        port_f_pin_oe,
    // Port G pads
    input  wire logic [4:0]        port_g_pin_in,
    output logic      [4:0]        port_g_pin_out,
    output logic      [4:0]        port_g_pin_oe,
    // Generic peripheral overrides, dir 1 = input
    input  wire logic [7:1]        f_ovr_en,
    input  wire logic [7:1]        f_ovr_dir,
    input  wire logic [7:1]        f_ovr_data,
    input  wire logic [4:0]        g_ovr_en,
    input  wire logic [4:0]        g_ovr_dir,
    input  wire logic [4:0]        g_ovr_data,
    // Enhanced capture channel 3 on G0
    input  wire logic              ccp3_out_en,
    input  wire logic              ccp3_out_data,
    input  wire logic              pwm_shutdown,
    output logic                   ccp3_capture_in,
    // Serial transceiver on G1
    input  wire logic              serial2_tx_en,
    input  wire logic              serial2_tx_data,
    input  wire logic              serial2_clk_ext,
    output logic                   serial2_clock_in,
    // Comparator three output on G1
    input  wire logic              comp3_out_en,
    input  wire logic              comp3_out_data,
    // Synchronous serial port slave select
    output logic                   serial_slave_select
);

    // Address decode reads bits 3:0, so a narrower bus cannot serve
    if (ADDR_W < 4) begin : g_addr_w_check
        $error("ADDR_W must be at least 4");
    end

    // Software-visible state
    logic [7:1] f_latch_reg;
    logic [7:1] f_dir_reg;
    logic [4:0] g_latch_reg;
    logic [4:0] g_dir_reg;
    logic [7:0] analog_low_reg;
    logic [7:0] analog_mid_reg;
    logic [7:0] analog_high_reg;
    logic [2:0] od_ctrl_reg;

    // Input synchronisers and filtered levels
    logic [7:1] f_s1_reg;
    logic [7:1] f_s2_reg;
    logic [7:1] f_s3_reg;
    logic [7:1] f_level_reg;
    logic [4:0] g_s1_reg;
    logic [4:0] g_s2_reg;
    logic [4:0] g_s3_reg;
    logic [4:0] g_level_reg;

    // Derived combinational values
    logic [7:1] f_analog;
    logic [4:0] g_analog;
    logic [7:1] f_oe_next;
    logic [7:1] f_out_next;
    logic [4:0] g_oe_next;
    logic [4:0] g_out_next;
    logic [7:0] rdata_next;
    logic [7:0] f_settled;
    logic [7:0] g_settled;

    function automatic logic wr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [3:0]        target);
        wr_hit = (a == ADDR_W'(target));
    endfunction : wr_hit

    function automatic logic [7:0] settle(input logic [7:0] s2,
                                          input logic [7:0] s3,
                                          input logic [7:0] held);
        settle = ((s2 ~^ s3) & s3) | ((s2 ^ s3) & held);
    endfunction : settle

    // Port F latch and direction, software only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            f_latch_reg <= F_LATCH_RESET;
            f_dir_reg   <= F_DIR_RESET;
        end else if (reg_wr) begin
            if (wr_hit(reg_addr, ADDR_F_PIN_DATA) ||
                wr_hit(reg_addr, ADDR_F_LATCH)) begin
                f_latch_reg <= reg_wdata[7:1];  // R20
            end
            if (wr_hit(reg_addr, ADDR_F_DIRECTION)) begin
                f_dir_reg <= reg_wdata[7:1];  // R12
            end
        end
    end

    // Port G latch and direction, software only
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            g_latch_reg <= G_LATCH_RESET;
            g_dir_reg   <= G_DIR_RESET;
        end else if (reg_wr) begin
            if (wr_hit(reg_addr, ADDR_G_PIN_DATA) ||
                wr_hit(reg_addr, ADDR_G_LATCH)) begin
                g_latch_reg <= reg_wdata[4:0];  // R09
            end
            if (wr_hit(reg_addr, ADDR_G_DIRECTION)) begin
                g_dir_reg <= reg_wdata[4:0];  // R12
            end
        end
    end

    // Analog select and open-drain controls
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            analog_low_reg  <= ANALOG_RESET;  // R19
            analog_mid_reg  <= ANALOG_RESET;  // R03
            analog_high_reg <= ANALOG_RESET;  // R17
            od_ctrl_reg     <= OD_CTRL_RESET;
        end else if (reg_wr) begin
            if (wr_hit(reg_addr, ADDR_ANALOG_LOW)) begin
                analog_low_reg <= reg_wdata;  // R06
            end
            if (wr_hit(reg_addr, ADDR_ANALOG_MID)) begin
                analog_mid_reg <= reg_wdata;
            end
            if (wr_hit(reg_addr, ADDR_ANALOG_HIGH)) begin
                analog_high_reg <= reg_wdata;
            end
            if (wr_hit(reg_addr, ADDR_OPEN_DRAIN)) begin
                od_ctrl_reg <= reg_wdata[2:0];  // R10
            end
        end
    end

    // Filtered levels: stage three once stages two and three agree
    always_comb begin
        f_settled = settle({f_s2_reg, 1'b0}, {f_s3_reg, 1'b0},
                           {f_level_reg, 1'b0});
        g_settled = settle({3'h0, g_s2_reg}, {3'h0, g_s3_reg},
                           {3'h0, g_level_reg});
    end

    // Pad input synchronisers, level taken once stages two and three agree
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            f_s1_reg    <= '0;
            f_s2_reg    <= '0;
            f_s3_reg    <= '0;
            f_level_reg <= '0;
            g_s1_reg    <= '0;
            g_s2_reg    <= '0;
            g_s3_reg    <= '0;
            g_level_reg <= '0;
        end else begin
            f_s1_reg    <= port_f_pin_in;
            f_s2_reg    <= f_s1_reg;
            f_s3_reg    <= f_s2_reg;
            f_level_reg <= f_settled[7:1];
            g_s1_reg    <= port_g_pin_in;
            g_s2_reg    <= g_s1_reg;
            g_s3_reg    <= g_s2_reg;
            g_level_reg <= g_settled[4:0];
        end
    end

    // Analog enables per pin
    always_comb begin
        f_analog = {analog_low_reg[AN_F7], analog_mid_reg[AN_F6],
                    analog_mid_reg[AN_F5], analog_mid_reg[AN_F4],
                    analog_mid_reg[AN_F3], analog_low_reg[AN_F2],
                    analog_low_reg[AN_F1]};
        g_analog = {analog_high_reg[AN_G4], analog_high_reg[AN_G3],
                    analog_high_reg[AN_G2], analog_high_reg[AN_G1], 1'b0};
    end

    // Port F drive: latch when direction clear, analog has no say
    always_comb begin
        f_oe_next  = (f_ovr_en & ~f_ovr_dir) | (~f_ovr_en & ~f_dir_reg);  // R11
        f_out_next = (f_ovr_en & f_ovr_data) | (~f_ovr_en & f_latch_reg);
        f_oe_next[6]  = f_ovr_en[6] ? ~f_ovr_dir[6] : ~f_dir_reg[6];  // R01
        f_out_next[6] = f_ovr_en[6] ? f_ovr_data[6] : f_latch_reg[6];
        f_oe_next[7]  = f_ovr_en[7] ? ~f_ovr_dir[7] : ~f_dir_reg[7];  // R04
        f_out_next[7] = f_ovr_en[7] ? f_ovr_data[7] : f_latch_reg[7];
    end

    // Port G drive with peripheral priorities
    always_comb begin
        g_oe_next  = (g_ovr_en & ~g_ovr_dir) | (~g_ovr_en & ~g_dir_reg);  // R11
        g_out_next = (g_ovr_en & g_ovr_data) | (~g_ovr_en & g_latch_reg);

        // G0: capture channel output when direction clear
        if (ccp3_out_en && !g_dir_reg[0]) begin
            g_oe_next[0]  = 1'b1;  // R13
            g_out_next[0] = ccp3_out_data;
            if (pwm_shutdown && od_ctrl_reg[OD_P3A_TRI]) begin
                g_oe_next[0] = 1'b0;  // R14
            end
            if (od_ctrl_reg[OD_CCP3]) begin
                g_oe_next[0]  = g_oe_next[0] & ~ccp3_out_data;  // R10
                g_out_next[0] = 1'b0;
            end
        end

        // G1: transmit wins, then comparator, then latch
        if (serial2_tx_en) begin
            g_oe_next[1]  = 1'b1;  // R15
            g_out_next[1] = serial2_tx_data;
            if (od_ctrl_reg[OD_SERIAL2]) begin
                g_oe_next[1]  = ~serial2_tx_data;  // R10
                g_out_next[1] = 1'b0;
            end
        end else if (comp3_out_en) begin
            g_oe_next[1]  = 1'b1;  // R21
            g_out_next[1] = comp3_out_data;  // R18
        end
    end

    // Registered pad drives
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            port_f_pin_out <= '0;
            port_f_pin_oe  <= '0;
            port_g_pin_out <= '0;
            port_g_pin_oe  <= '0;
        end else begin
            port_f_pin_out <= f_out_next;
            port_f_pin_oe  <= f_oe_next;
            port_g_pin_out <= g_out_next;
            port_g_pin_oe  <= g_oe_next;
        end
    end

    // Digital inputs handed to peripherals
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            serial_slave_select <= 1'b1;
            ccp3_capture_in     <= 1'b0;
            serial2_clock_in    <= 1'b0;
        end else begin
            serial_slave_select <= f_dir_reg[7] ? f_level_reg[7] : 1'b1;  // R07
            ccp3_capture_in     <= g_level_reg[0];
            serial2_clock_in    <= (g_dir_reg[1] && serial2_clk_ext)
                                   ? g_level_reg[1] : 1'b0;  // R16
        end
    end

    // Read multiplexer
    always_comb begin
        case (reg_addr[3:0])
            ADDR_F_PIN_DATA: begin
                rdata_next = {f_level_reg & ~f_analog, 1'b0};  // R02 R05 R08
            end
            ADDR_F_LATCH: begin
                rdata_next = {f_latch_reg, 1'b0};  // R20
            end
            ADDR_F_DIRECTION: begin
                rdata_next = {f_dir_reg, 1'b0};  // R12
            end
            ADDR_ANALOG_LOW: begin
                rdata_next = analog_low_reg;
            end
            ADDR_ANALOG_MID: begin
                rdata_next = analog_mid_reg;
            end
            ADDR_ANALOG_HIGH: begin
                rdata_next = analog_high_reg;
            end
            ADDR_G_PIN_DATA: begin
                rdata_next = {3'h0, g_level_reg & ~g_analog};
            end
            ADDR_G_LATCH: begin
                rdata_next = {3'h0, g_latch_reg};
            end
            ADDR_G_DIRECTION: begin
                rdata_next = {3'h0, g_dir_reg};
            end
            ADDR_OPEN_DRAIN: begin
                rdata_next = {5'h00, od_ctrl_reg};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
        if (reg_addr[ADDR_W-1:0] != ADDR_W'(reg_addr[3:0])) begin
            rdata_next = 8'h00;
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : io_port_pin_sharing_slice

`default_nettype wire

// ==== gpio_slice_pkg.sv ====
// Register map, field positions and reset values for the I/O port slice.
// Assumes a byte-wide register port with a small word address.
package gpio_slice_pkg;

    // Register addresses
    localparam logic [3:0] ADDR_F_PIN_DATA   = 4'h0;
    localparam logic [3:0] ADDR_F_LATCH      = 4'h1;
    localparam logic [3:0] ADDR_F_DIRECTION  = 4'h2;
    localparam logic [3:0] ADDR_ANALOG_LOW   = 4'h3;
    localparam logic [3:0] ADDR_ANALOG_MID   = 4'h4;
    localparam logic [3:0] ADDR_ANALOG_HIGH  = 4'h5;
    localparam logic [3:0] ADDR_G_PIN_DATA   = 4'h6;
    localparam logic [3:0] ADDR_G_LATCH      = 4'h7;
    localparam logic [3:0] ADDR_G_DIRECTION  = 4'h8;
    localparam logic [3:0] ADDR_OPEN_DRAIN   = 4'h9;

    // Widths
    localparam int F_PINS = 7;
    localparam int G_PINS = 5;

    // Reset values: latches clear, pins input, analog selected
    localparam logic [7:1] F_LATCH_RESET  = 7'h00;
    localparam logic [7:1] F_DIR_RESET    = 7'h7f;
    localparam logic [4:0] G_LATCH_RESET  = 5'h00;
    localparam logic [4:0] G_DIR_RESET    = 5'h1f;
    localparam logic [7:0] ANALOG_RESET   = 8'hff;
    localparam logic [2:0] OD_CTRL_RESET  = 3'h0;

    // Analog enable bit positions for each pin
    localparam int AN_F1 = 6;  // low register
    localparam int AN_F2 = 7;  // low register
    localparam int AN_F3 = 0;  // mid register
    localparam int AN_F4 = 1;  // mid register
    localparam int AN_F5 = 2;  // mid register
    localparam int AN_F6 = 3;  // mid register, channel eleven
    localparam int AN_F7 = 5;  // low register, channel five
    localparam int AN_G1 = 3;  // high register, channel nineteen
    localparam int AN_G2 = 2;  // high register
    localparam int AN_G3 = 1;  // high register
    localparam int AN_G4 = 0;  // high register

    // Open-drain and shutdown control fields
    localparam int OD_CCP3    = 0;
    localparam int OD_SERIAL2 = 1;
    localparam int OD_P3A_TRI = 2;

endpackage : gpio_slice_pkg

// ==== io_port_pin_sharing_slice_props.sv ====
// Checker for the I/O port slice: register read timing and pin muxing.
// Assumes one-cycle strobes and level peripheral controls.
`timescale 1ns/1ps
`default_nettype none
module io_port_pin_sharing_slice_props
    import gpio_slice_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              rst_b,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    // Pads
    input wire logic [7:1]        port_f_pin_out,
    input wire logic [7:1]        port_f_pin_oe,
    input wire logic [4:0]        port_g_pin_out,
    input wire logic [4:0]        port_g_pin_oe,
    // Peripheral controls
    input wire logic [7:1]        f_ovr_en,
    input wire logic [4:0]        g_ovr_en,
    input wire logic [4:0]        g_ovr_dir,
    input wire logic [4:0]        g_ovr_data,
    input wire logic              serial2_tx_en,
    input wire logic              serial2_tx_data,
    input wire logic              comp3_out_en,
    input wire logic              comp3_out_data
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_f_bit0;
        reg_rd && reg_addr <= ADDR_F_DIRECTION |=> reg_rdata[0] == 1'b0;
    endproperty
    a_f_bit0: assert property (p_f_bit0) else $error("port f bit0 set");
    property p_g_top;
        reg_rd && reg_addr == ADDR_G_DIRECTION |=> reg_rdata[7:5] == 3'h0;
    endproperty
    a_g_top: assert property (p_g_top) else $error("g dir top bits set");
    property p_f6_oe;
        reg_wr && reg_addr == ADDR_F_DIRECTION && !reg_wdata[6] ##1
        !(reg_wr && reg_addr == ADDR_F_DIRECTION) && !f_ovr_en[6]
        |=> port_f_pin_oe[6];
    endproperty
    a_f6_oe: assert property (p_f6_oe) else $error("f6 not driving");
    property p_f7_out;
        reg_wr && reg_addr <= ADDR_F_LATCH ##1
        !(reg_wr && reg_addr <= ADDR_F_LATCH) && !f_ovr_en[7]
        |=> port_f_pin_oe[7] -> port_f_pin_out[7] == $past(reg_wdata[7], 2);
    endproperty
    a_f7_out: assert property (p_f7_out) else $error("f7 latch lost");
    property p_tx;
        serial2_tx_en |=> port_g_pin_out[1] == $past(serial2_tx_data)
            && port_g_pin_oe[1] || !port_g_pin_out[1]
            && port_g_pin_oe[1] == !$past(serial2_tx_data);
    endproperty
    a_tx: assert property (p_tx) else $error("g1 transmit lost");
    property p_comp;
        comp3_out_en && !serial2_tx_en |=> port_g_pin_oe[1]
            && port_g_pin_out[1] == $past(comp3_out_data);
    endproperty
    a_comp: assert property (p_comp) else $error("g1 comparator lost");
    property p_g2_ovr;
        g_ovr_en[2] |=> port_g_pin_oe[2] == !$past(g_ovr_dir[2]) &&
            (port_g_pin_oe[2] -> port_g_pin_out[2] == $past(g_ovr_data[2]));
    endproperty
    a_g2_ovr: assert property (p_g2_ovr) else $error("g2 override lost");
    c_tx: cover property (serial2_tx_en && serial2_tx_data);
    c_rd_g: cover property (reg_rd && reg_addr == ADDR_G_PIN_DATA);
    c_ovr: cover property (g_ovr_en[2] && !g_ovr_dir[2]);
endmodule : io_port_pin_sharing_slice_props

bind io_port_pin_sharing_slice io_port_pin_sharing_slice_props #(
    .ADDR_W(ADDR_W)
) props_i (
    .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .port_f_pin_out, .port_f_pin_oe, .port_g_pin_out, .port_g_pin_oe,
    .f_ovr_en, .g_ovr_en, .g_ovr_dir, .g_ovr_data, .serial2_tx_en,
    .serial2_tx_data, .comp3_out_en, .comp3_out_data
);
`default_nettype wire

// ==== board_pad_model.sv ====
// Board pads: each pad follows the slice when driven, else the board.
// Assumes the board drives every pad that the slice leaves undriven.
`timescale 1ns/1ps
`default_nettype none
module board_pad_model #(
    parameter int W = 7
) (
    // Slice side
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe,
    // Board side
    input  wire logic [W-1:0] ext_drive,
    output logic      [W-1:0] pin_level
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_level[i] = pin_oe[i] ? pin_out[i] : ext_drive[i];
        end
    end
endmodule : board_pad_model
`default_nettype wire

// ==== io_port_pin_sharing_slice_bench.sv ====
// Bench for the I/O port slice: registers, pin muxing and overrides.
// Assumes the pad model resolves each pad from both drivers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin \
    err_total++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module io_port_pin_sharing_slice_bench import gpio_slice_pkg::*;;
    logic       core_clk, rst_b, reg_wr, reg_rd;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, v;
    logic [7:1] port_f_pin_in, port_f_pin_out, port_f_pin_oe, f_ext;
    logic [7:1] f_ovr_en, f_ovr_dir, f_ovr_data;
    logic [4:0] port_g_pin_in, port_g_pin_out, port_g_pin_oe, g_ext;
    logic [4:0] g_ovr_en, g_ovr_dir, g_ovr_data;
    logic       ccp3_out_en, ccp3_out_data, pwm_shutdown, ccp3_capture_in;
    logic       serial2_tx_en, serial2_tx_data, serial2_clk_ext;
    logic       serial2_clock_in, comp3_out_en, comp3_out_data;
    logic       serial_slave_select;
    int         err_total, n_tests, cyc, a, seed, mreg[16];

    io_port_pin_sharing_slice io_port_pin_sharing_slice_i (
        .core_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .port_f_pin_in, .port_f_pin_out, .port_f_pin_oe,
        .port_g_pin_in, .port_g_pin_out, .port_g_pin_oe, .f_ovr_en,
        .f_ovr_dir, .f_ovr_data, .g_ovr_en, .g_ovr_dir, .g_ovr_data,
        .ccp3_out_en, .ccp3_out_data, .pwm_shutdown, .ccp3_capture_in,
        .serial2_tx_en, .serial2_tx_data, .serial2_clk_ext,
        .serial2_clock_in, .comp3_out_en, .comp3_out_data,
        .serial_slave_select);
    board_pad_model #(.W(7)) f_pads_i (.pin_out(port_f_pin_out),
        .pin_oe(port_f_pin_oe), .ext_drive(f_ext), .pin_level(port_f_pin_in));
    board_pad_model #(.W(5)) g_pads_i (.pin_out(port_g_pin_out),
        .pin_oe(port_g_pin_oe), .ext_drive(g_ext), .pin_level(port_g_pin_in));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    function automatic int msk(input int a);
        if (a < 3) return 'hfe;
        if (a < 6) return 'hff;
        if (a < 9) return 'h1f;
        return (a == 9) ? 'h07 : 0;
    endfunction : msk
    task automatic wr(input int a, input int d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= 4'(a);
        reg_wdata <= 8'(d);
        @(posedge core_clk);
        reg_wr <= 1'b0;
        mreg[(a == 0 || a == 6) ? a + 1 : a] = d & msk(a);
    endtask : wr
    task automatic rd(input int a);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= 4'(a);
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(posedge core_clk);
        v = reg_rdata;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : settle
    task automatic results;
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results

    initial begin
        seed = 32'hc190;
        {reg_wr, reg_rd, reg_addr, reg_wdata, f_ext, g_ext} = '0;
        {f_ovr_en, f_ovr_dir, f_ovr_data, g_ovr_en, g_ovr_dir} = '0;
        {g_ovr_data, ccp3_out_en, ccp3_out_data, pwm_shutdown} = '0;
        {serial2_tx_en, serial2_tx_data, serial2_clk_ext} = '0;
        {comp3_out_en, comp3_out_data} = '0;
        rst_b = 1'b0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'b1;
        mreg = '{0, 0, 'hfe, 'hff, 'hff, 'hff, 0, 0, 'h1f, 0, 0, 0, 0, 0, 0, 0};
        for (int i = 0; i < 16; i++) begin
            rd(i);
            `CHK("reset reg", mreg[i], v)
        end
        // Outputs drive while analog still selected
        wr(ADDR_F_DIRECTION, 0);
        wr(ADDR_G_DIRECTION, 0);
        wr(ADDR_F_PIN_DATA, $random(seed));
        wr(ADDR_G_PIN_DATA, $random(seed));
        settle(2);
        `CHK("f oe", 7'h7f, port_f_pin_oe)
        `CHK("f out", mreg[1] >> 1, port_f_pin_out)
        `CHK("g oe", 5'h1f, port_g_pin_oe)
        `CHK("g out", mreg[7], port_g_pin_out)
        // Random writes under peripheral overrides
        for (int i = 0; i < 30; i++) begin
            a = $random(seed) & 15;
            f_ovr_en  <= 7'($random(seed));
            f_ovr_dir <= 7'($random(seed));
            wr(a, $random(seed) & 'hff);
            a = (a == 0 || a == 6) ? a + 1 : a;
            rd(a);
            `CHK("reg rw", mreg[a], v)
        end
        f_ovr_en <= '0;
        wr(ADDR_F_DIRECTION, 'hfe);
        wr(ADDR_G_DIRECTION, 'h1f);
        wr(ADDR_OPEN_DRAIN, 0);
        f_ext <= 7'($random(seed));
        g_ext <= 5'($random(seed));
        for (int k = 1; k >= 0; k--) begin
            for (int i = 3; i < 6; i++) begin
                wr(i, k * 'hff);
            end
            settle(6);
            rd(ADDR_F_PIN_DATA);
            `CHK("f pins", k ? 0 : {f_ext, 1'b0}, v)
            rd(ADDR_G_PIN_DATA);
            `CHK("g pins", k ? g_ext & 1 : g_ext, v)
        end
        `CHK("slave sel", f_ext[7], serial_slave_select)
        `CHK("capture", g_ext[0], ccp3_capture_in)
        serial2_clk_ext <= 1'b1;
        settle(6);
        `CHK("ser clk", g_ext[1], serial2_clock_in)
        // G1 shared functions with the pin set as input
        serial2_tx_en   <= 1'b1;
        serial2_tx_data <= 1'b1;
        settle(2);
        `CHK("tx", 2'b11, {port_g_pin_oe[1], port_g_pin_out[1]})
        wr(ADDR_OPEN_DRAIN, 'h02);
        settle(2);
        `CHK("tx od", 1'b0, port_g_pin_oe[1])
        wr(ADDR_OPEN_DRAIN, 0);
        serial2_tx_en  <= 1'b0;
        comp3_out_en   <= 1'b1;
        comp3_out_data <= 1'b1;
        settle(2);
        `CHK("comp", 2'b11, {port_g_pin_oe[1], port_g_pin_out[1]})
        comp3_out_en <= 1'b0;
        // G0 channel 3 output and shutdown tristate
        wr(ADDR_G_DIRECTION, 'h1e);
        ccp3_out_en   <= 1'b1;
        ccp3_out_data <= !mreg[7][0];
        settle(2);
        `CHK("ccp3 oe", 1'b1, port_g_pin_oe[0])
        `CHK("ccp3 out", ccp3_out_data, port_g_pin_out[0])
        pwm_shutdown <= 1'b1;
        wr(ADDR_OPEN_DRAIN, 'h04);
        settle(2);
        `CHK("shutdown", 1'b0, port_g_pin_oe[0])
        // Generic overrides on F4, F5 and G2
        wr(ADDR_F_DIRECTION, 0);
        f_ovr_en   <= 7'h18;
        f_ovr_dir  <= 7'h08;
        f_ovr_data <= 7'h10;
        g_ovr_en   <= 5'h04;
        g_ovr_data <= 5'h04;
        settle(2);
        `CHK("ovr", 3'b101, {port_f_pin_oe[5:4], port_f_pin_out[5]})
        rd(ADDR_F_DIRECTION);
        `CHK("dir kept", mreg[2], v)
        rst_b <= 1'b0;
        settle(2);
        `CHK("rst oe", 0, {port_f_pin_oe, port_g_pin_oe})
        rst_b <= 1'b1;
        rd(ADDR_F_DIRECTION);
        `CHK("rst dir", 'hfe, v)
        results();
    end
endmodule : io_port_pin_sharing_slice_bench
`default_nettype wire
